//--- core/ebtec_pkg.sv
// constants and types for the three 8-bit timer/event counters
package ebtec_pkg;
  localparam int          NUM_TIMERS   = 3;
  localparam logic [11:0] OFF_CTRL0    = 12'h000;
  localparam logic [11:0] OFF_CTRL1    = 12'h004;
  localparam logic [11:0] OFF_CTRL2    = 12'h008;
  localparam logic [11:0] OFF_PRE0     = 12'h00C;
  localparam logic [11:0] OFF_PRE1     = 12'h010;
  localparam logic [11:0] OFF_PRE2     = 12'h014;
  localparam logic [11:0] OFF_CNT0     = 12'h018;
  localparam logic [11:0] OFF_CNT1     = 12'h01C;
  localparam logic [11:0] OFF_CNT2     = 12'h020;
  localparam logic [11:0] OFF_IEN      = 12'h024;
  localparam logic [11:0] OFF_PWMEN    = 12'h028;
  localparam int          BIT_CLKSEL   = 5;
  localparam int          BIT_RUN      = 4;
  localparam int          BIT_EDGE     = 3;
  localparam int          MODE_HI      = 7;
  localparam int          MODE_LO      = 6;
  localparam logic [7:0]  CTRL_RESET   = 8'h08;
  localparam logic [7:0]  CTRL1_MASK   = 8'hF8;
  localparam logic [7:0]  CTRL2_MASK   = 8'hDF;
  localparam logic [7:0]  CNT_FULL     = 8'hFF;
  localparam logic [7:0]  PRE_DEFAULT  = 8'h00;
  localparam logic [6:0]  PSC_ONE      = 7'h01;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  typedef enum logic [1:0] {
    MODE_NONE  = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } ebtec_mode_t;
endpackage

//--- core/ebtec_timers.sv
// three 8-bit count-up timer/event counters with apb register access
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module ebtec_timers
  import ebtec_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        lxtClk,
  input  wire logic [2:0]  extTimerIn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic [2:0]       overflowPulse,
  output logic [2:0]       timerIrq,
  output logic             wakeUp
);
  import ebtec_pkg::*;

  logic [7:0] ctrl    [NUM_TIMERS];
  logic [7:0] preload [NUM_TIMERS];
  logic [7:0] count   [NUM_TIMERS];
  logic [2:0] irqEnable;
  logic       pwmEnabled;
  logic [2:0] pinMeta, pinSync, pinLast;
  logic       lxtMeta, lxtSync, lxtLast;
  logic       lxtRise;
  logic [1:0] div4;
  logic       sysDiv4Tick;
  logic [2:0] tickRaw;
  logic [2:0] capActive;
  logic [2:0] ovf;
  logic [2:0] capEnd;
  logic [2:0] preWrite;
  logic       wrAccess;
  logic       baseTick;
  logic [31:0] next_prdata;
  logic        addrOk;

  // writes land only at the edge that completes the transfer; a master
  // holding its access phase past pready writes the same word again two cycles later
  assign wrAccess = psel && penable && pwrite && pready;

  // lxt sampled as a level; its rise becomes a one-cycle tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lxtMeta <= 1'b0;
      lxtSync <= 1'b0;
      lxtLast <= 1'b0;
    end else begin
      lxtMeta <= lxtClk;
      lxtSync <= lxtMeta;
      lxtLast <= lxtSync;
    end
  end
  assign lxtRise = lxtSync && !lxtLast;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div4 <= 2'h0;
    end else begin
      div4 <= div4 + 2'h1;
    end
  end
  assign sysDiv4Tick = (div4 == DIV4_LAST);

  // pwm override wins over the base clock select of timer 0
  assign baseTick = (pwmEnabled || !ctrl[0][BIT_CLKSEL]) ? 1'b1
                                                         : lxtRise;

  // external pin: two-flop synchroniser, edges on the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
      pinLast <= 3'h0;
    end else begin
      pinMeta <= extTimerIn;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_TIMERS; i++) begin : g_tmr
      ebtec_mode_t mode;
      logic        rise, fall, edgeSel, run, internalTick, clkTick;
      logic        pscTick, actEdge, endEdge;
      logic [6:0]  pscMask;
      logic [6:0]  pscCnt;

      assign mode    = ebtec_mode_t'(ctrl[i][MODE_HI:MODE_LO]);
      assign run     = ctrl[i][BIT_RUN];
      assign edgeSel = ctrl[i][BIT_EDGE];
      assign rise    = pinSync[i] && !pinLast[i];
      assign fall    = !pinSync[i] && pinLast[i];

      if (i == 1) begin : g_t1
        // no prescaler on this timer
        assign internalTick = ctrl[i][BIT_CLKSEL] ? lxtRise
                                                  : sysDiv4Tick;
        assign pscTick = internalTick;
        assign pscMask = 7'h00;
      end else begin : g_tp
        assign internalTick = baseTick;
        assign pscMask = 7'(({7'h00, PSC_ONE} << ctrl[i][2:0]) - 14'h1);
        // tick when the divider wraps: ratio 2**code
        assign pscTick = internalTick &&
                         ((pscCnt & pscMask) == pscMask);
      end

      if (i != 1) begin : g_pscnt
        always_ff @(posedge sys_clk or negedge rst_n) begin
          if (!rst_n) begin
            pscCnt <= 7'h00;
          end else if (internalTick) begin
            pscCnt <= pscCnt + 7'h01;
          end
        end
        // the divider only moves on base ticks
        a_psc_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
          !internalTick |=> $stable(pscCnt))
          else $error("prescaler moved without tick");
      end else begin : g_nopsc
        assign pscCnt = 7'h00;
      end

      // edgeSel 0: start on fall, stop on rise; 1 the reverse
      assign actEdge = edgeSel ? rise : fall;
      assign endEdge = edgeSel ? fall : rise;

      always_comb begin
        case (mode)
          MODE_EVENT: clkTick = run && (edgeSel ? fall : rise);
          MODE_TIMER: clkTick = run && pscTick;
          MODE_PULSE: clkTick = run && capActive[i] && pscTick;
          default:    clkTick = 1'b0;
        endcase
      end

      assign ovf[i]    = clkTick && (count[i] == CNT_FULL);
      assign capEnd[i] = (mode == MODE_PULSE) && run && capActive[i]
                         && endEdge;

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          capActive[i] <= 1'b0;
        end else if (mode != MODE_PULSE || !run || capEnd[i]) begin
          capActive[i] <= 1'b0;
        end else if (actEdge) begin
          capActive[i] <= 1'b1;
        end
      end

      assign preWrite[i] = wrAccess &&
        (paddr == (i == 0 ? OFF_PRE0 : i == 1 ? OFF_PRE1 : OFF_PRE2));

      // preload: no reset, power-on content is whatever is there
      always_ff @(posedge sys_clk) begin
        if (preWrite[i]) begin
          preload[i] <= pwdata[7:0];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          count[i] <= PRE_DEFAULT;
        end else if (preWrite[i] && !run) begin
          count[i] <= pwdata[7:0];
        end else if (ovf[i]) begin
          count[i] <= preload[i];
        end else if (clkTick) begin
          count[i] <= count[i] + 8'h01;
        end
      end

      // per-timer checks, one set for each counter
      a_ovf_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ovf[i] |=> overflowPulse[i])
        else $error("overflow pulse missing");
      a_none_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == MODE_NONE && !preWrite[i] |=> $stable(count[i]))
        else $error("count moved with no mode");
      a_irq_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
        timerIrq[i] |-> overflowPulse[i])
        else $error("irq without overflow");
      a_ien_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ovf[i] && !irqEnable[i] |=> !timerIrq[i])
        else $error("irq passed while disabled");
      a_run_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        preWrite[i] && run && clkTick && !ovf[i]
        |=> count[i] == $past(count[i]) + 8'h01)
        else $error("running preload write hit count");
      a_timer_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == MODE_TIMER && run && pscTick && !ovf[i]
        |=> count[i] == $past(count[i]) + 8'h01)
        else $error("timer tick lost");
      a_event_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == MODE_EVENT && run && (edgeSel ? fall : rise) && !ovf[i]
        |=> count[i] == $past(count[i]) + 8'h01)
        else $error("selected edge not counted");
      a_cap_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        capEnd[i] |=> !capActive[i])
        else $error("capture still active");
    end
  endgenerate

  // control registers; hardware clear of run wins over a software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl[0] <= CTRL_RESET;
      ctrl[1] <= CTRL_RESET;
      ctrl[2] <= CTRL_RESET;
    end else begin
      if (wrAccess && paddr == OFF_CTRL0) begin
        ctrl[0] <= pwdata[7:0];
      end
      if (wrAccess && paddr == OFF_CTRL1) begin
        ctrl[1] <= pwdata[7:0] & CTRL1_MASK;
      end
      if (wrAccess && paddr == OFF_CTRL2) begin
        ctrl[2] <= pwdata[7:0] & CTRL2_MASK;
      end
      for (int k = 0; k < NUM_TIMERS; k++) begin
        if (capEnd[k]) begin
          ctrl[k][BIT_RUN] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnable  <= 3'h0;
      pwmEnabled <= 1'b0;
    end else begin
      if (wrAccess && paddr == OFF_IEN) begin
        irqEnable <= pwdata[2:0];
      end
      if (wrAccess && paddr == OFF_PWMEN) begin
        pwmEnabled <= pwdata[0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflowPulse <= 3'h0;
      timerIrq      <= 3'h0;
      wakeUp        <= 1'b0;
    end else begin
      overflowPulse <= ovf;
      timerIrq      <= ovf & irqEnable;
      wakeUp        <= |ovf;
    end
  end

  always_comb begin
    addrOk      = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      OFF_CTRL0: next_prdata[7:0] = ctrl[0];
      OFF_CTRL1: next_prdata[7:0] = ctrl[1];
      OFF_CTRL2: next_prdata[7:0] = ctrl[2];
      OFF_PRE0:  next_prdata[7:0] = preload[0];
      OFF_PRE1:  next_prdata[7:0] = preload[1];
      OFF_PRE2:  next_prdata[7:0] = preload[2];
      OFF_CNT0:  next_prdata[7:0] = count[0];
      OFF_CNT1:  next_prdata[7:0] = count[1];
      OFF_CNT2:  next_prdata[7:0] = count[2];
      OFF_IEN:   next_prdata[2:0] = irqEnable;
      OFF_PWMEN: next_prdata[0]   = pwmEnabled;
      default:   addrOk = 1'b0;
    endcase
  end

  // one wait state: answer in the first access cycle's following edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addrOk;
      prdata  <= (psel && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  a_ctrl1_low_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[1][2:0] == 3'h0) else $error("timer1 low bits not zero");
  a_ctrl2_bit5: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[2][BIT_CLKSEL]) else $error("timer2 bit5 set");
  a_ovf_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf[0] && !preWrite[0] |=> count[0] == $past(preload[0]))
    else $error("no reload on overflow");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    timerIrq[0] |-> $past(irqEnable[0]) && overflowPulse[0])
    else $error("irq without enable");
  a_stop_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[0][BIT_RUN] && !preWrite[0] |=> $stable(count[0]))
    else $error("count moved while stopped");
  a_stopped_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    preWrite[0] && !ctrl[0][BIT_RUN] |=> count[0] == $past(pwdata[7:0]))
    else $error("stopped preload not copied");
  a_cap_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    capEnd[2] |=> !ctrl[2][BIT_RUN]) else $error("capture run kept");
  a_cap_armed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[2][MODE_HI:MODE_LO] == MODE_PULSE && !capActive[2] && !ovf[2]
    && !preWrite[2] |=> $stable(count[2])) else $error("capture early");
  a_event_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[2][MODE_HI:MODE_LO] == MODE_EVENT && ctrl[2][BIT_RUN]
    && !preWrite[2] && !ovf[2] && !pinSync[2] && pinLast[2]
    && ctrl[2][BIT_EDGE] |=> count[2] == $past(count[2]) + 8'h01)
    else $error("event edge missed");

  // shared base clock, wake-up and bus answer
  a_pwm_base: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pwmEnabled |-> baseTick)
    else $error("pwm did not force system clock");
  a_lxt_base: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pwmEnabled && ctrl[0][BIT_CLKSEL] |-> baseTick == lxtRise)
    else $error("base clock not crystal");
  a_wake_any: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |ovf |=> wakeUp)
    else $error("wake missing on overflow");
  a_pready_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("pready held two cycles");
  a_slverr_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("error without ready");

  c_overflow: cover property (@(posedge sys_clk) disable iff (!rst_n)
    overflowPulse[0]);
  c_capture: cover property (@(posedge sys_clk) disable iff (!rst_n)
    capEnd[2]);
  c_event: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ovf[1] && ctrl[1][MODE_HI:MODE_LO] == MODE_EVENT);
  c_held_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
    preWrite[0] && ctrl[0][BIT_RUN]);
  c_lxt_base: cover property (@(posedge sys_clk) disable iff (!rst_n)
    lxtRise && ctrl[0][BIT_CLKSEL]);
endmodule

`default_nettype wire

//--- sim/ebtec_pin_src.sv
// external pin source: toggles one timer pin a set number of times
`timescale 1ns/10ps
`default_nettype none
module ebtec_pin_src (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [1:0] pinSel,
  input  wire logic [7:0] nToggle,
  input  wire logic [7:0] halfLen,
  output logic [2:0]      extTimerIn,
  output logic            busy
);
  logic [7:0] left;
  logic [7:0] tick;
  // a pin holds its level between bursts, as a real driven source does
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      extTimerIn <= 3'h0;
      left <= 8'h00;
      tick <= 8'h00;
      busy <= 1'b0;
    end else if (go) begin
      left <= nToggle;
      tick <= halfLen;
      busy <= 1'b1;
    end else if (left != 8'h00) begin
      if (tick == 8'h01) begin
        extTimerIn[pinSel] <= ~extTimerIn[pinSel];
        left <= left - 8'h01;
        tick <= halfLen;
      end else begin
        tick <= tick - 8'h01;
      end
    end else begin
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/ebtec_timers_tb.sv
// self-checking bench for the timer/event counters
`timescale 1ns/10ps
`default_nettype none
module ebtec_timers_tb;
  import ebtec_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        lxtClk = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, wakeUp, busy;
  logic [31:0] prdata, r, w;
  logic [2:0]  ovf, irq, pin;
  logic        go = 1'b0;
  logic        e;
  logic [1:0]  sel = 2'h0;
  logic [7:0]  nTog = 8'h00;
  logic [7:0]  half = 8'h04;
  int          n_mismatch = 0;
  int          n_compared = 0;
  ebtec_timers uut (.sys_clk(sys_clk), .rst_n(rst_n), .lxtClk(lxtClk),
    .extTimerIn(pin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .overflowPulse(ovf), .timerIrq(irq), .wakeUp(wakeUp));
  ebtec_pin_src src (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
    .pinSel(sel), .nToggle(nTog), .halfLen(half), .extTimerIn(pin),
    .busy(busy));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // crystal period deliberately not a multiple of the system period
  initial begin
    forever #163 lxtClk = ~lxtClk;
  end
  task automatic chk(input string nm, input logic [31:0] lo, hi, got);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'h1, {31'h0, pready});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] lo, hi);
    apb(1'b0, a, 32'h0);
    chk(nm, lo, hi, r);
  endtask
  // the interval between the second and third overflow avoids phase slop
  task automatic per(input int t, input int lo, hi, input logic ien);
    int k;
    for (int n = 0; n < 3; n++) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (ovf[t] !== 1'b1 && k < 6000);
    end
    chk("period", lo, hi, k);
    chk("irq", {31'h0, ien}, {31'h0, ien}, {31'h0, irq[t]});
    chk("wake", 32'h1, 32'h1, {31'h0, wakeUp});
  endtask
  task automatic tog(input logic [7:0] n, h);
    int k;
    k = 0;
    sel <= 2'h2;
    nTog <= n;
    half <= h;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (busy === 1'b1 && k < 3000);
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic capt(input logic [7:0] c, h, input int lo, hi);
    wr(OFF_CTRL2, c & 8'hEF);
    wr(OFF_PRE2, 8'h00);
    wr(OFF_CTRL2, c);
    repeat (50) @(posedge sys_clk);
    rd("armed", OFF_CNT2, 32'h0, 32'h0);
    tog(8'h02, h);
    rd("width", OFF_CNT2, lo, hi);
    rd("autostop", OFF_CTRL2, c & 8'hEF, c & 8'hEF);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd("ctrl0", OFF_CTRL0, 32'h08, 32'h08);
    rd("ctrl1", OFF_CTRL1, 32'h08, 32'h08);
    rd("ctrl2", OFF_CTRL2, 32'h08, 32'h08);
    wr(OFF_IEN, 8'h00);
    wr(OFF_PWMEN, 8'h00);
    wr(OFF_CTRL1, 8'hFF);
    rd("ctrl1", OFF_CTRL1, 32'hF8, 32'hF8);
    wr(OFF_CTRL2, 8'hFF);
    rd("ctrl2", OFF_CTRL2, 32'hDF, 32'hDF);
    wr(OFF_CTRL1, 8'h08);
    wr(OFF_CTRL2, 8'h08);
    apb(1'b0, 12'h030, 32'h0);
    chk("slverr", 32'h1, 32'h1, {31'h0, e});
    wr(OFF_PRE0, 8'h33);
    rd("cnt0", OFF_CNT0, 32'h33, 32'h33);
    wr(OFF_CTRL0, 8'h10);
    repeat (100) @(posedge sys_clk);
    rd("cnt0", OFF_CNT0, 32'h33, 32'h33);
    wr(OFF_CTRL0, 8'h80);
    repeat (100) @(posedge sys_clk);
    rd("cnt0", OFF_CNT0, 32'h33, 32'h33);
    wr(OFF_PRE0, 8'hF0);
    for (int p = 0; p < 8; p++) begin
      wr(OFF_CTRL0, 8'h90 | 8'(p));
      per(0, 16 << p, 16 << p, 1'b0);
    end
    wr(OFF_IEN, 8'h01);
    wr(OFF_CTRL0, 8'h90);
    wr(OFF_PRE0, 8'hF8);
    per(0, 8, 8, 1'b1);
    wr(OFF_CTRL0, 8'hB0);
    per(0, 250, 270, 1'b1);
    wr(OFF_PWMEN, 8'h01);
    per(0, 8, 8, 1'b1);
    wr(OFF_PWMEN, 8'h00);
    wr(OFF_PRE2, 8'hF8);
    wr(OFF_CTRL2, 8'h90);
    per(2, 250, 270, 1'b0);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_PRE1, 8'hF0);
    wr(OFF_CTRL1, 8'h90);
    per(1, 64, 64, 1'b0);
    wr(OFF_CTRL1, 8'hB0);
    per(1, 505, 535, 1'b0);
    wr(OFF_CTRL1, 8'h08);
    wr(OFF_CTRL2, 8'h08);
    wr(OFF_PRE2, 8'h00);
    wr(OFF_CTRL2, 8'h57);
    tog(8'h05, 8'h04);
    rd("rise", OFF_CNT2, 32'h3, 32'h3);
    wr(OFF_CTRL2, 8'h4F);
    wr(OFF_PRE2, 8'h00);
    wr(OFF_CTRL2, 8'h5F);
    tog(8'h05, 8'h04);
    rd("fall", OFF_CNT2, 32'h3, 32'h3);
    capt(8'hD8, 8'h28, 38, 42);
    rd("held", OFF_CNT2, 32'h26, 32'h2A);
    w = r;
    tog(8'h01, 8'h04);
    rd("ignored", OFF_CNT2, w, w);
    capt(8'hD0, 8'h1E, 28, 32);
    print_verdict;
  end
endmodule
`default_nettype wire
